// file: hdl/adsp_port.sv
`default_nettype none
// How it works
// RULE1 - Mode 0 target; input bit captured on each rising serial clock edge.
// RULE2 - Read data bit changes on falling serial clock edges only.
// RULE3 - One transaction per continuous chip select low period.
// RULE4 - Data phase is one, two or three bytes by register width.
// RULE5 - Write word executes at rising edge 16, 24 or 32 by width.
// RULE6 - Host aborts by raising chip select before the executing edge.
// RULE7 - Reads and writes do nothing until wakeup has completed.
// RULE8 - While selected, output pin shows the interrupt indication.
// RULE9 - On reads, interrupt shown until 9th falling edge, then read data.
// RULE10 - Host never chains a read and a write in one frame.
// RULE11 - A write aborts any running calibration or conversion.
// RULE12 - Reads never disturb calibration or conversion.
// RULE13 - Address and data shifted most significant bit first.
// RULE14 - Width follows register function; user side reports it per address.
// RULE15 - Address byte top bit: 0 write, 1 read.
// RULE16 - Low seven address bits select register and thus frame length.
// RULE17 - Counters and shift state reset while chip select is high.
// RULE18 - Output pin undriven while chip select is high.
module adsp_port
    import adsp_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic mosi,
    output logic serial_out_irq_pin_o,
    output logic serial_out_irq_pin_oe,
    input wire logic irq_indication_n,
    input wire logic wake_done,
    input wire logic conv_busy,
    output adsp_pkg::adsp_hdr_t acc_hdr,
    input wire adsp_pkg::adsp_width_t acc_width,
    output logic rd_req,
    input wire logic [adsp_pkg::WORD_MAX-1:0] rd_data,
    output logic wr_stb,
    output logic [adsp_pkg::WORD_MAX-1:0] wr_data,
    output logic conv_abort
);
    import adsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] pins_s;
    logic sclk_s;
    logic csn_s;
    logic mosi_s;

    adsp_sync #(
        .W(3),
        .INIT(3'h2)
    ) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .d({sclk, chip_select_n, mosi}),
        .q(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign csn_s = pins_s[1];
    assign mosi_s = pins_s[0];

    ////////////////////////////////////////////////////////////////////////////
    // State
    adsp_state_t st_r;
    adsp_state_t st_nxt;
    logic rise_w;
    logic fall_w;
    logic [CNT_W-1:0] rise_inc;
    logic [CNT_W-1:0] frame_end;

    assign rise_w = sclk_s && !st_r.sclk_d && !csn_s; // RULE1
    assign fall_w = !sclk_s && st_r.sclk_d && !csn_s; // RULE2
    assign rise_inc = st_r.rise_cnt + 6'h01;
    assign frame_end = adsp_frame_bits(acc_width); // RULE4 RULE14 RULE16

    always_comb begin
        st_nxt = st_r;
        st_nxt.sclk_d = sclk_s;
        st_nxt.wr_stb = 1'b0;
        st_nxt.rd_req = 1'b0;
        st_nxt.abort = 1'b0;
        st_nxt.rd_load = 1'b0;
        if (csn_s) begin
            // Frame boundary; a partial frame is dropped here
            st_nxt.rise_cnt = CNT_RESET; // RULE17 RULE3 RULE6
            st_nxt.fall_cnt = CNT_RESET;
            st_nxt.shin = '0;
            st_nxt.shout = '0;
            st_nxt.data_ph = 1'b0;
            st_nxt.oe = 1'b0; // RULE18
            st_nxt.sdo = 1'b0;
        end else begin
            st_nxt.oe = 1'b1;
            if (rise_w && st_r.rise_cnt < BITS_W24) begin
                st_nxt.rise_cnt = rise_inc;
                st_nxt.shin = {st_r.shin[WORD_MAX-2:0], mosi_s}; // RULE1 RULE13
                if (rise_inc == HDR_LAST) begin
                    st_nxt.hdr.is_read = st_r.shin[DIR_BIT-1]; // RULE15
                    st_nxt.hdr.addr = {st_r.shin[5:0], mosi_s}; // RULE16
                    st_nxt.rd_req = st_r.shin[DIR_BIT-1] && wake_done; // RULE7
                    st_nxt.rd_load = st_r.shin[DIR_BIT-1];
                end
                if (rise_inc == frame_end && !st_r.hdr.is_read && wake_done) begin
                    // Only one execution per frame: count only rises and stops at 32
                    st_nxt.wr_stb = 1'b1; // RULE5 RULE7 RULE10
                    st_nxt.wr_data = {st_r.shin[WORD_MAX-2:0], mosi_s} &
                        adsp_mask(acc_width);
                    st_nxt.abort = conv_busy; // RULE11 RULE12
                end
            end
            if (st_r.rd_load) begin
                // Left-align so the register MSB leaves first
                unique case (acc_width)
                    ADSP_W8: st_nxt.shout = {rd_data[7:0], 16'h0000};
                    ADSP_W16: st_nxt.shout = {rd_data[15:0], 8'h00};
                    ADSP_W24: st_nxt.shout = rd_data;
                endcase
                if (!wake_done) st_nxt.shout = '0; // RULE7
            end
            if (fall_w && st_r.fall_cnt < BITS_W24) begin
                st_nxt.fall_cnt = st_r.fall_cnt + 6'h01;
            end
            if (fall_w && st_r.hdr.is_read &&
                    (st_r.data_ph || st_r.fall_cnt == FALL_TO_DATA) &&
                    st_r.rise_cnt > HDR_LAST) begin
                st_nxt.data_ph = 1'b1; // RULE9
                st_nxt.sdo = st_r.shout[WORD_MAX-1]; // RULE2 RULE13
                st_nxt.shout = {st_r.shout[WORD_MAX-2:0], 1'b0};
            end else if (!st_r.data_ph) begin
                st_nxt.sdo = irq_indication_n; // RULE8
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign serial_out_irq_pin_o = st_r.sdo;
    assign serial_out_irq_pin_oe = st_r.oe;
    assign acc_hdr = st_r.hdr;
    assign rd_req = st_r.rd_req;
    assign wr_stb = st_r.wr_stb;
    assign wr_data = st_r.wr_data;
    assign conv_abort = st_r.abort;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_capture;
        @(posedge core_clk) disable iff (srst)
        (rise_w && st_r.rise_cnt < BITS_W24) |=> st_r.shin[0] == $past(mosi_s);
    endproperty
    a_capture: assert property (p_capture) else $error("input bit not captured"); // RULE1

    property p_out_fall;
        @(posedge core_clk) disable iff (srst)
        ($past(st_r.data_ph) && st_r.data_ph && !$past(fall_w)) |-> $stable(st_r.sdo);
    endproperty
    a_out_fall: assert property (p_out_fall) else $error("data out moved off fall"); // RULE2

    property p_exec_edge;
        @(posedge core_clk) disable iff (srst)
        st_r.wr_stb |-> (st_r.rise_cnt == $past(frame_end)) && !st_r.hdr.is_read;
    endproperty
    a_exec_edge: assert property (p_exec_edge) else $error("write at wrong edge"); // RULE5

    property p_asleep;
        @(posedge core_clk) disable iff (srst)
        !$past(wake_done) |-> !st_r.wr_stb && !st_r.rd_req;
    endproperty
    a_asleep: assert property (p_asleep) else $error("access before wakeup"); // RULE7

    property p_irq_show;
        @(posedge core_clk) disable iff (srst)
        (!csn_s && !st_r.data_ph && !fall_w) |=> st_r.sdo == $past(irq_indication_n);
    endproperty
    a_irq_show: assert property (p_irq_show) else $error("irq not presented"); // RULE8

    property p_data_switch;
        @(posedge core_clk) disable iff (srst)
        (fall_w && st_r.hdr.is_read && st_r.fall_cnt == FALL_TO_DATA &&
            st_r.rise_cnt > HDR_LAST) |=> st_r.data_ph && st_r.oe;
    endproperty
    a_data_switch: assert property (p_data_switch) else $error("no switch at 9th fall"); // RULE9

    property p_abort;
        @(posedge core_clk) disable iff (srst)
        st_r.wr_stb |-> st_r.abort == $past(conv_busy);
    endproperty
    a_abort: assert property (p_abort) else $error("write did not abort conversion"); // RULE11

    property p_read_quiet;
        @(posedge core_clk) disable iff (srst)
        st_r.hdr.is_read |-> !st_r.abort;
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("read aborted conversion"); // RULE12

    property p_idle_reset;
        @(posedge core_clk) disable iff (srst)
        csn_s |=> st_r.rise_cnt == CNT_RESET && !st_r.data_ph && !st_r.oe;
    endproperty
    a_idle_reset: assert property (p_idle_reset) else $error("state kept unselected"); // RULE17

    property p_hiz;
        @(posedge core_clk) disable iff (srst)
        $past(csn_s) |-> !serial_out_irq_pin_oe;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pin driven while deselected"); // RULE18

endmodule // adsp_port
`default_nettype wire

// file: pkg/adsp_pkg.sv
`default_nettype none
package adsp_pkg;

    localparam int ADDR_BITS = 8;
    localparam int WORD_MAX = 24;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
    localparam logic [CNT_W-1:0] HDR_LAST = 6'h08;
    localparam logic [CNT_W-1:0] BITS_W8 = 6'h10;
    localparam logic [CNT_W-1:0] BITS_W16 = 6'h18;
    localparam logic [CNT_W-1:0] BITS_W24 = 6'h20;
    // Falling edges seen before the 9th one
    localparam logic [CNT_W-1:0] FALL_TO_DATA = 6'h08;
    localparam int DIR_BIT = 7;

    typedef enum logic [1:0] {
        ADSP_W8,
        ADSP_W16,
        ADSP_W24
    } adsp_width_t;

    typedef struct packed {
        logic is_read;
        logic [6:0] addr;
    } adsp_hdr_t;

    typedef struct packed {
        logic [CNT_W-1:0] rise_cnt;
        logic [CNT_W-1:0] fall_cnt;
        logic [WORD_MAX-1:0] shin;
        adsp_hdr_t hdr;
        logic data_ph;
        logic rd_load;
        logic [WORD_MAX-1:0] shout;
        logic sdo;
        logic oe;
        logic sclk_d;
        logic wr_stb;
        logic rd_req;
        logic abort;
        logic [WORD_MAX-1:0] wr_data;
    } adsp_state_t;

    function automatic logic [CNT_W-1:0] adsp_frame_bits(adsp_width_t w);
        unique case (w)
            ADSP_W8: adsp_frame_bits = BITS_W8;
            ADSP_W16: adsp_frame_bits = BITS_W16;
            ADSP_W24: adsp_frame_bits = BITS_W24;
            default: adsp_frame_bits = BITS_W24;
        endcase
    endfunction

    function automatic logic [WORD_MAX-1:0] adsp_mask(adsp_width_t w);
        unique case (w)
            ADSP_W8: adsp_mask = 24'h0000FF;
            ADSP_W16: adsp_mask = 24'h00FFFF;
            default: adsp_mask = 24'hFFFFFF;
        endcase
    endfunction

endpackage
`default_nettype wire

// file: hdl/adsp_sync.sv
`default_nettype none
module adsp_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // Refuse an empty synchroniser at elaboration
    if (W < 1) begin : g_bad_w
        $error("adsp_sync: W must be at least 1");
    end

    logic [W-1:0] meta_r;

    // Two flops per bit; the first is read only by the second
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge core_clk) begin
            if (srst) begin
                meta_r[i] <= INIT[i];
                q[i] <= INIT[i];
            end else begin
                meta_r[i] <= d[i];
                q[i] <= meta_r[i];
            end
        end
    end
endmodule // adsp_sync
`default_nettype wire

// file: sim/adsp_host_model.sv
`default_nettype none
module adsp_host_model (
    output logic sclk,
    output logic chip_select_n,
    output logic mosi,
    input wire logic pin
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // One frame; a stop_at within the frame cancels before that rise
    task automatic xfer(input logic [7:0] hdr, input int nbits, input logic [23:0] wd,
            input int stop_at, output logic [23:0] rdv, output logic irq_seen);
        logic [31:0] sh;
        int n;
        sh = {hdr, wd << (24 - nbits)};
        n = 8 + nbits;
        rdv = '0;
        irq_seen = 1'b0;
        chip_select_n <= 1'b0;
        #40;
        for (int i = 1; i <= n; i++) begin
            if (i == stop_at) break;
            mosi <= sh[31];
            sh = sh << 1;
            #32 sclk <= 1'b1;
            #32;
            if (i == 9) irq_seen = pin;
            if (i >= 10) rdv = {rdv[22:0], pin};
            sclk <= 1'b0;
        end
        #32;
        if (hdr[7] && stop_at > n) rdv = {rdv[22:0], pin};
        chip_select_n <= 1'b1;
        mosi <= ~mosi;
        #60;
    endtask
endmodule // adsp_host_model
`default_nettype wire

// file: sim/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import adsp_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic irq_indication_n = 1'b1;
    logic wake_done = 1'b0;
    logic conv_busy = 1'b0;
    logic [WORD_MAX-1:0] rd_word = '0;
    logic [WORD_MAX-1:0] rd_data;
    logic sclk, chip_select_n, mosi, pin_o, pin_oe, rd_req, wr_stb, conv_abort, irq_seen;
    wire pin_w;
    adsp_hdr_t acc_hdr;
    adsp_width_t acc_width;
    logic [WORD_MAX-1:0] wr_data, rdv;
    logic [6:0] adr [3] = '{7'h05, 7'h2A, 7'h55};
    int bad_count = 0, check_count = 0;
    // Four-state so an unknown strobe poisons the count
    integer wr_n = 0, rd_n = 0, ab_n = 0;
    assign pin_w = pin_oe ? pin_o : 1'bz;
    // Responder answers only in the cycle the design asks
    assign rd_data = rd_req ? rd_word : '0;
    assign acc_width = acc_hdr.addr[6] ? ADSP_W24 : (acc_hdr.addr[5] ? ADSP_W16 : ADSP_W8);
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (!srst) begin
            wr_n <= wr_n + wr_stb;
            rd_n <= rd_n + rd_req;
            ab_n <= ab_n + conv_abort;
        end
    end
    adsp_host_model i_host (.sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi),
        .pin(pin_w));
    adsp_port i_dut (.core_clk(core_clk), .srst(srst), .sclk(sclk),
        .chip_select_n(chip_select_n), .mosi(mosi), .serial_out_irq_pin_o(pin_o),
        .serial_out_irq_pin_oe(pin_oe), .irq_indication_n(irq_indication_n),
        .wake_done(wake_done), .conv_busy(conv_busy), .acc_hdr(acc_hdr),
        .acc_width(acc_width), .rd_req(rd_req), .rd_data(rd_data), .wr_stb(wr_stb),
        .wr_data(wr_data), .conv_abort(conv_abort));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic t_wake();
        i_host.xfer({1'b0, adr[0]}, 8, 24'h0000C3, 99, rdv, irq_seen);
        i_host.xfer({1'b1, adr[0]}, 8, 24'h0, 99, rdv, irq_seen);
        chk("asleep wr", 24'(wr_n), 24'h000000);
        chk("asleep rd", 24'(rd_n), 24'h000000);
        chk("asleep data", rdv, 24'h000000);
        @(posedge core_clk) wake_done <= 1'b1;
        $display("test wake done");
    endtask
    task automatic t_write();
        int w0;
        int a0;
        for (int k = 0; k < 3; k++) begin
            w0 = wr_n;
            a0 = ab_n;
            @(posedge core_clk) conv_busy <= (k == 2);
            i_host.xfer({1'b0, adr[k]}, 8 * (k + 1), 24'hA5C33C, 99, rdv, irq_seen);
            chk("wr count", 24'(wr_n - w0), 24'h000001);
            chk("wr data", wr_data, 24'hA5C33C & ~(24'hFFFFFF << (8 * (k + 1))));
            chk("hdr", 24'(acc_hdr), {17'h0, adr[k]});
            chk("abort", 24'(ab_n - a0), 24'(k == 2));
        end
        $display("test write done");
    endtask
    task automatic t_abort();
        int w0;
        w0 = wr_n;
        i_host.xfer({1'b0, adr[2]}, 24, 24'h123456, 16, rdv, irq_seen);
        i_host.xfer({1'b0, adr[2]}, 24, 24'h123456, 32, rdv, irq_seen);
        chk("cancel wr", 24'(wr_n - w0), 24'h000000);
        i_host.xfer({1'b0, adr[0]}, 8, 24'h00005A, 99, rdv, irq_seen);
        chk("after cancel", wr_data, 24'h00005A);
        $display("test abort done");
    endtask
    task automatic t_read();
        int r0;
        int a0;
        for (int k = 0; k < 3; k++) begin
            r0 = rd_n;
            a0 = ab_n;
            @(posedge core_clk) rd_word <= 24'h5A3C96;
            irq_indication_n <= (k == 1);
            i_host.xfer({1'b1, adr[k]}, 8 * (k + 1), 24'h0, 99, rdv, irq_seen);
            chk("rd data", rdv, 24'h5A3C96 & ~(24'hFFFFFF << (8 * (k + 1))));
            chk("rd count", 24'(rd_n - r0), 24'h000001);
            chk("no abort", 24'(ab_n - a0), 24'h000000);
            chk("irq", {23'h0, irq_seen}, 24'(k == 1));
            chk("oe idle", {23'h0, pin_oe}, 24'h000000);
        end
        $display("test read done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_wake();
        t_write();
        t_abort();
        t_read();
        give_verdict();
    end
    initial begin
        #200000;
        bad_count++;
        $display("Error watchdog expected end seen timeout");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
